// >>> hdl/cable_diag_pkg.sv
package cable_diag_pkg;

	// management register offsets
	localparam logic [4:0] ADDR_INT_CTRL = 5'h11;
	localparam logic [4:0] ADDR_INT_STAT_MASK = 5'h12;
	localparam logic [4:0] ADDR_PAGE_SEL = 5'h13;
	localparam logic [4:0] ADDR_REFLECT_CONTROL = 5'h16;
	localparam logic [4:0] ADDR_REFLECT_WINDOW = 5'h17;
	localparam logic [4:0] ADDR_REFLECT_PEAK = 5'h18;
	localparam logic [4:0] ADDR_REFLECT_THRESH = 5'h19;
	localparam logic [4:0] ADDR_QUALITY_CTRL = 5'h1D;
	localparam logic [4:0] ADDR_QUALITY_DATA = 5'h1E;
	localparam logic [2:0] DIAG_PAGE = 3'h2;

	// reflect_control fields
	localparam int CTRL_ENABLE_BIT = 15;
	localparam int CTRL_100MB_BIT = 14;
	localparam int CTRL_TX_ON_RX_BIT = 13;
	localparam int CTRL_MON_RX_BIT = 12;
	localparam int CTRL_SEND_BIT = 11;
	localparam int CTRL_WIDTH_LSB = 8;
	localparam int CTRL_MIN_MODE_BIT = 7;
	localparam int CTRL_THRESH_LSB = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// reflect_window fields
	localparam int WIN_START_LSB = 8;
	localparam int WIN_STOP_LSB = 0;
	localparam logic [15:0] WIN_RESET = 16'h00FF;

	// result fields
	localparam int RES_TIME_LSB = 8;
	localparam int THR_FOUND_BIT = 0;

	// quality monitor fields
	localparam int QMON_ENABLE_BIT = 15;
	localparam int QDATA_WRITE_BIT = 14;
	localparam int QDATA_SAMPLE_BIT = 13;
	localparam int QDATA_SEL_LSB = 9;
	localparam int QDATA_HIGH_BIT = 8;
	localparam int NUM_PARAMS = 5;
	localparam logic [2:0] PARAM_GAIN = 3'h1;
	localparam logic [7:0] SIGNED_MIN = 8'h80;
	localparam logic [7:0] SIGNED_MAX = 8'h7F;
	localparam logic [7:0] UNSIGNED_MIN = 8'h00;
	localparam logic [7:0] UNSIGNED_MAX = 8'hFF;

	// interrupt control fields
	localparam int INTCTRL_OE_BIT = 0;
	localparam int INTCTRL_ENABLE_BIT = 1;
	localparam int INTMASK_QUALITY_BIT = 7;
	localparam int INTSTAT_QUALITY_BIT = 15;

	// timing, in 8ns sample steps
	localparam int SAMPLE_NS = 8;
	localparam int LINK_SHORT_NS = 50;
	localparam int LINK_LONG_NS = 100;
	localparam int LINK_SHORT_SAMPLES = (LINK_SHORT_NS + SAMPLE_NS - 1) / SAMPLE_NS;
	localparam int LINK_LONG_SAMPLES = (LINK_LONG_NS + SAMPLE_NS - 1) / SAMPLE_NS;
	localparam logic [7:0] TIMER_LAST = 8'hFF;

endpackage

// >>> hdl/cable_link_diagnostics.sv
`timescale 1ns/1ps
module cable_link_diagnostics
	import cable_diag_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// management register port
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// adapted receiver parameters
	input wire logic [7:0] equalizer_first_coeff_i,
	input wire logic [7:0] digital_gain_control_i,
	input wire logic [7:0] baseline_wander_value_i,
	input wire logic [7:0] freq_offset_i,
	input wire logic [7:0] recovered_clock_control_i,
	// converter samples, one valid per 8ns step
	input wire logic adc_valid_i,
	input wire logic [7:0] adc_sample_i,
	// line driver and pair control
	output logic diag_active_o,
	output logic line_driver_10mb_o,
	output logic line_driver_100mb_o,
	output logic pulse_negative_o,
	output logic pulse_on_rx_pair_o,
	output logic monitor_rx_pair_o,
	// interrupt
	output logic int_n_o
);

	typedef struct packed {
		logic [2:0] page;
		logic [1:0] int_ctrl;
		logic [7:0] int_mask;
		logic quality_pending;
		logic [15:0] ctrl;
		logic [15:0] win;
		logic qmon_enable;
		logic [2*NUM_PARAMS-1:0] warn;
		logic [2*NUM_PARAMS-1:0][7:0] thr;
		logic [7:0] qdata;
		logic running;
		logic [7:0] timer;
		logic [3:0] pulse_left;
		logic polarity;
		logic peak_seen;
		logic [7:0] peak_val;
		logic [7:0] peak_time;
		logic thr_found;
		logic [7:0] thr_time;
		logic [15:0] rdata;
		logic drv10;
		logic drv100;
		logic neg;
		logic int_n;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] thr_default(input int idx);
		logic is_gain;
		logic is_high;
		is_gain = (idx / 2) == int'(PARAM_GAIN);
		is_high = idx[0];
		if (is_gain)
			return is_high ? UNSIGNED_MAX : UNSIGNED_MIN;
		return is_high ? SIGNED_MAX : SIGNED_MIN;
	endfunction

	// strict greater-than, signedness per parameter
	function automatic logic exceeds(input logic [7:0] a, input logic [7:0] b,
		input logic unsigned_cmp);
		if (unsigned_cmp)
			return a > b;
		return $signed(a) > $signed(b);
	endfunction

	function automatic logic [3:0] pulse_samples(input logic [2:0] width,
		input logic mode100);
		if (width == 3'h0)
			return 4'h0;
		if (mode100)
			return {1'b0, width};
		// short link pulse for narrow codes, long otherwise
		return width[2] ? 4'(LINK_LONG_SAMPLES) : 4'(LINK_SHORT_SAMPLES);
	endfunction

	logic [NUM_PARAMS-1:0][7:0] param_val;
	assign param_val = {recovered_clock_control_i, freq_offset_i, baseline_wander_value_i,
		digital_gain_control_i, equalizer_first_coeff_i};

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic diag_page;
		logic [2*NUM_PARAMS-1:0] warn_now;
		logic [3:0] thr_idx;
		logic [2:0] sel;
		logic launch;
		logic min_mode;
		logic qualify;
		logic signed [8:0] thr_level;
		logic [2:0] width;
		state_nxt = state_r;
		diag_page = state_r.page == DIAG_PAGE;
		warn_now = '0;
		thr_idx = 4'h0;
		sel = reg_wdata_i[QDATA_SEL_LSB +: 3];
		launch = 1'b0;
		min_mode = state_r.ctrl[CTRL_MIN_MODE_BIT];
		qualify = 1'b0;
		thr_level = 9'sh000;
		width = state_r.ctrl[CTRL_WIDTH_LSB +: 3];

		// quality comparisons
		for (int p = 0; p < NUM_PARAMS; p++) begin
			logic u;
			u = 3'(p) == PARAM_GAIN;
			if (state_r.qmon_enable) begin
				warn_now[2*p] = exceeds(state_r.thr[2*p], param_val[p], u);
				warn_now[2*p+1] = exceeds(param_val[p], state_r.thr[2*p+1], u);
			end
		end

		// read side: answer registered, read of status registers clears them
		state_nxt.rdata = 16'h0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_INT_CTRL: state_nxt.rdata = {14'h0000, state_r.int_ctrl};
				ADDR_INT_STAT_MASK: begin
					state_nxt.rdata = {state_r.quality_pending, 7'h00, state_r.int_mask};
					state_nxt.quality_pending = 1'b0;
				end
				ADDR_PAGE_SEL: state_nxt.rdata = {13'h0000, state_r.page};
				default: begin
					if (diag_page) begin
						case (reg_addr_i)
							ADDR_REFLECT_CONTROL: state_nxt.rdata = state_r.ctrl;
							ADDR_REFLECT_WINDOW: state_nxt.rdata = state_r.win;
							ADDR_REFLECT_PEAK:
								state_nxt.rdata = {state_r.peak_time, state_r.peak_val};
							ADDR_REFLECT_THRESH:
								state_nxt.rdata = {state_r.thr_time, 7'h00, state_r.thr_found};
							ADDR_QUALITY_CTRL: begin
								state_nxt.rdata = {state_r.qmon_enable, 5'h00, state_r.warn};
								state_nxt.warn = '0;
							end
							ADDR_QUALITY_DATA: state_nxt.rdata = {8'h00, state_r.qdata};
							default: state_nxt.rdata = 16'h0000;
						endcase
					end
				end
			endcase
		end

		// write side
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_INT_CTRL: state_nxt.int_ctrl = reg_wdata_i[1:0];
				ADDR_INT_STAT_MASK: state_nxt.int_mask = reg_wdata_i[7:0];
				ADDR_PAGE_SEL: state_nxt.page = reg_wdata_i[2:0];
				default: begin
					if (diag_page) begin
						case (reg_addr_i)
							ADDR_REFLECT_CONTROL: begin
								state_nxt.ctrl = reg_wdata_i;
								state_nxt.ctrl[CTRL_SEND_BIT] = 1'b0;
								// send ignored while reflectometry is off
								launch = reg_wdata_i[CTRL_SEND_BIT] &
									reg_wdata_i[CTRL_ENABLE_BIT];
							end
							ADDR_REFLECT_WINDOW: state_nxt.win = reg_wdata_i;
							ADDR_QUALITY_CTRL:
								state_nxt.qmon_enable = reg_wdata_i[QMON_ENABLE_BIT];
							ADDR_QUALITY_DATA: begin
								thr_idx = {sel, reg_wdata_i[QDATA_HIGH_BIT]};
								if (reg_wdata_i[QDATA_SAMPLE_BIT]) begin
									if (sel < 3'(NUM_PARAMS))
										state_nxt.qdata = param_val[sel];
									else
										state_nxt.qdata = 8'h00;
								end else if (thr_idx < 4'(2 * NUM_PARAMS)) begin
									if (reg_wdata_i[QDATA_WRITE_BIT])
										state_nxt.thr[thr_idx] = reg_wdata_i[7:0];
									state_nxt.qdata = reg_wdata_i[QDATA_WRITE_BIT] ?
										reg_wdata_i[7:0] : state_r.thr[thr_idx];
								end else begin
									state_nxt.qdata = 8'h00;
								end
							end
							default: ;
						endcase
					end
				end
			endcase
		end

		// new warnings win over a clearing read
		state_nxt.warn = state_nxt.warn | warn_now;
		if (|warn_now)
			state_nxt.quality_pending = 1'b1;
		state_nxt.int_n = ~(state_r.int_ctrl[INTCTRL_ENABLE_BIT] &
			state_r.int_ctrl[INTCTRL_OE_BIT] &
			state_r.int_mask[INTMASK_QUALITY_BIT] & state_r.quality_pending);

		// reflection monitor
		if (!state_r.ctrl[CTRL_ENABLE_BIT]) begin
			state_nxt.running = 1'b0;
			state_nxt.pulse_left = 4'h0;
		end else if (state_r.running && adc_valid_i) begin
			qualify = state_r.timer >= state_r.win[WIN_START_LSB +: 8] &&
				state_r.timer <= state_r.win[WIN_STOP_LSB +: 8];
			thr_level = {3'b000, state_r.ctrl[CTRL_THRESH_LSB +: 6]};
			if (qualify) begin
				if (!state_r.peak_seen ||
					(min_mode ? $signed(adc_sample_i) < $signed(state_r.peak_val) :
					$signed(adc_sample_i) > $signed(state_r.peak_val))) begin
					state_nxt.peak_seen = 1'b1;
					state_nxt.peak_val = adc_sample_i;
					state_nxt.peak_time = state_r.timer;
				end
				if (!state_r.thr_found &&
					(min_mode ? $signed({adc_sample_i[7], adc_sample_i}) < -thr_level :
					$signed({adc_sample_i[7], adc_sample_i}) > thr_level)) begin
					state_nxt.thr_found = 1'b1;
					state_nxt.thr_time = state_r.timer;
				end
			end
			if (state_r.pulse_left != 4'h0)
				state_nxt.pulse_left = state_r.pulse_left - 4'h1;
			state_nxt.timer = state_r.timer + 8'h01;
			if (state_r.timer == TIMER_LAST)
				state_nxt.running = 1'b0;
		end

		if (launch) begin
			state_nxt.running = 1'b1;
			state_nxt.timer = 8'h00;
			state_nxt.pulse_left = pulse_samples(reg_wdata_i[CTRL_WIDTH_LSB +: 3],
				reg_wdata_i[CTRL_100MB_BIT]);
			state_nxt.peak_seen = 1'b0;
			state_nxt.peak_val = 8'h00;
			state_nxt.peak_time = 8'h00;
			state_nxt.thr_found = 1'b0;
			state_nxt.thr_time = 8'h00;
			if (reg_wdata_i[CTRL_100MB_BIT] && reg_wdata_i[CTRL_WIDTH_LSB +: 3] != 3'h0)
				state_nxt.polarity = ~state_r.polarity;
		end

		// drivers follow the pulse counter
		state_nxt.drv10 = state_nxt.pulse_left != 4'h0 &&
			!state_nxt.ctrl[CTRL_100MB_BIT];
		state_nxt.drv100 = state_nxt.pulse_left != 4'h0 &&
			state_nxt.ctrl[CTRL_100MB_BIT];
		state_nxt.neg = state_nxt.drv100 && state_nxt.polarity;
		if (width == 3'h0 && !launch)
			state_nxt.neg = state_nxt.neg; // nothing: zero width keeps drivers idle
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= '0;
			state_r.ctrl <= CTRL_RESET;
			state_r.win <= WIN_RESET;
			state_r.int_n <= 1'b1;
			for (int i = 0; i < 2 * NUM_PARAMS; i++)
				state_r.thr[i] <= thr_default(i);
		end else begin
			state_r <= state_nxt;
		end
	end

	assign reg_rdata_o = state_r.rdata;
	assign diag_active_o = state_r.ctrl[CTRL_ENABLE_BIT];
	assign line_driver_10mb_o = state_r.drv10;
	assign line_driver_100mb_o = state_r.drv100;
	assign pulse_negative_o = state_r.neg;
	assign pulse_on_rx_pair_o = state_r.ctrl[CTRL_TX_ON_RX_BIT];
	assign monitor_rx_pair_o = state_r.ctrl[CTRL_MON_RX_BIT];
	assign int_n_o = state_r.int_n;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	logic wr_diag;
	assign wr_diag = reg_wr_i && state_r.page == DIAG_PAGE;

	chk_send_needs_enable: assert property (
		wr_diag && reg_addr_i == ADDR_REFLECT_CONTROL && !reg_wdata_i[CTRL_ENABLE_BIT]
		|=> !state_r.running)
		else $error("send accepted while reflectometry disabled");

	chk_launch_starts: assert property (
		wr_diag && reg_addr_i == ADDR_REFLECT_CONTROL &&
		reg_wdata_i[CTRL_ENABLE_BIT] && reg_wdata_i[CTRL_SEND_BIT]
		|=> state_r.running && state_r.timer == 8'h00 && !state_r.peak_seen)
		else $error("launch did not start monitor");

	chk_zero_width_quiet: assert property (
		wr_diag && reg_addr_i == ADDR_REFLECT_CONTROL && reg_wdata_i[CTRL_ENABLE_BIT] &&
		reg_wdata_i[CTRL_SEND_BIT] && reg_wdata_i[CTRL_WIDTH_LSB +: 3] == 3'h0
		|=> !line_driver_10mb_o && !line_driver_100mb_o && state_r.running)
		else $error("zero width pulse drove the line");

	chk_width_100mb: assert property (
		wr_diag && reg_addr_i == ADDR_REFLECT_CONTROL && reg_wdata_i[CTRL_ENABLE_BIT] &&
		reg_wdata_i[CTRL_SEND_BIT] && reg_wdata_i[CTRL_100MB_BIT] &&
		reg_wdata_i[CTRL_WIDTH_LSB +: 3] != 3'h0
		|=> line_driver_100mb_o && state_r.pulse_left == {1'b0, $past(reg_wdata_i[10:8])})
		else $error("100Mb pulse width wrong");

	chk_one_driver: assert property (
		!(line_driver_10mb_o && line_driver_100mb_o))
		else $error("both drivers active");

	chk_warn_needs_enable: assert property (
		!state_r.qmon_enable && !reg_rd_i |=> state_r.warn == $past(state_r.warn))
		else $error("warning raised while monitor disabled");

	chk_int_gating: assert property (
		!int_n_o |-> $past(state_r.quality_pending && state_r.int_ctrl == 2'b11 &&
		state_r.int_mask[INTMASK_QUALITY_BIT]))
		else $error("interrupt without enables");

	chk_page_gate: assert property (
		reg_rd_i && state_r.page != DIAG_PAGE && reg_addr_i >= ADDR_REFLECT_CONTROL
		|=> reg_rdata_o == 16'h0000)
		else $error("diagnostic register visible off page");

	chk_peak_window: assert property (
		$rose(state_r.peak_seen) |-> state_r.peak_time >= state_r.win[15:8] &&
		state_r.peak_time <= state_r.win[7:0])
		else $error("peak recorded outside window");

	cov_launch_100: cover property (line_driver_100mb_o && pulse_negative_o);
	cov_launch_10: cover property (line_driver_10mb_o);
	cov_thr_hit: cover property ($rose(state_r.thr_found));
	cov_quality_int: cover property ($fell(int_n_o));

endmodule // cable_link_diagnostics

// >>> dv/cable_model.sv
`timescale 1ns/1ps
// far end of the pair: echo of a sent pulse after a set delay, else small noise
module cable_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// run control from the bench
	input wire logic start_i,
	input wire logic [7:0] delay_i,
	input wire logic [7:0] amp_i,
	// line drivers of the block
	input wire logic drv_10mb_i,
	input wire logic drv_100mb_i,
	// converter side
	output logic adc_valid_o,
	output logic [7:0] adc_sample_o
);
	logic [8:0] step_r;
	logic sent_r;
	logic [8:0] echo_at;
	assign echo_at = {1'b0, delay_i};
	// step 0 is the first sample the monitor times as 0
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			step_r <= 9'h1FF;
			sent_r <= 1'b0;
		end else if (start_i) begin
			step_r <= 9'h000;
			sent_r <= 1'b0;
		end else begin
			if (step_r != 9'h1FF)
				step_r <= step_r + 9'h001;
			if (drv_10mb_i || drv_100mb_i)
				sent_r <= 1'b1;
		end
	end
	// no pulse sent means no echo, only line noise
	always_comb begin
		adc_sample_o = step_r[0] ? 8'h01 : 8'hFF;
		if (sent_r && step_r == echo_at + 9'h001)
			adc_sample_o = amp_i;
		else if (sent_r && (step_r == echo_at || step_r == echo_at + 9'h002))
			adc_sample_o = {amp_i[7], amp_i[7:1]};
	end
	assign adc_valid_o = nrst_i;
endmodule // cable_model

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cable_diag_pkg::*;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [4:0] reg_addr_i = 5'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] prm [5] = '{default: 8'h00};
	logic [15:0] reg_rdata_o;
	logic adc_valid, diag_active_o, drv10, drv100, neg_o, onrx_o, monrx_o, int_n_o;
	logic [7:0] adc_sample;
	logic start = 1'b0;
	logic [7:0] dly = 8'h20;
	logic [7:0] amp = 8'h40;
	logic neg_seen = 1'b0;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n10 = 0;
	int n100 = 0;

	cable_link_diagnostics dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .equalizer_first_coeff_i(prm[0]),
		.digital_gain_control_i(prm[1]), .baseline_wander_value_i(prm[2]),
		.freq_offset_i(prm[3]), .recovered_clock_control_i(prm[4]), .adc_valid_i(adc_valid),
		.adc_sample_i(adc_sample), .diag_active_o(diag_active_o), .line_driver_10mb_o(drv10),
		.line_driver_100mb_o(drv100), .pulse_negative_o(neg_o), .pulse_on_rx_pair_o(onrx_o),
		.monitor_rx_pair_o(monrx_o), .int_n_o(int_n_o));
	cable_model far_u (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start), .delay_i(dly),
		.amp_i(amp), .drv_10mb_i(drv10), .drv_100mb_i(drv100), .adc_valid_o(adc_valid),
		.adc_sample_o(adc_sample));

	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n10 += int'(drv10 === 1'b1);
		n100 += int'(drv100 === 1'b1);
		if (drv100 === 1'b1)
			neg_seen <= neg_o;
	end
	// all runs together stay well under this
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic rc(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		// read data stands for one cycle only, so look before the next edge
		check(reg_rdata_o & m, exp);
	endtask
	function automatic int exp_len(input logic m100, input logic [2:0] w);
		if (w == 3'h0)
			return 0;
		if (m100)
			return int'(w);
		return (w <= 3'h3) ? LINK_SHORT_SAMPLES : LINK_LONG_SAMPLES;
	endfunction
	task automatic run(input logic [15:0] ctrl, input logic [7:0] d, input logic [7:0] a);
		@(negedge clk_i);
		dly = d;
		amp = a;
		n10 = 0;
		n100 = 0;
		reg_addr_i = ADDR_REFLECT_CONTROL;
		reg_wdata_i = ctrl;
		reg_wr_i = 1'b1;
		start = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
		start = 1'b0;
		repeat (265) @(negedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] ctrl;
		logic [7:0] d, a, st, sp, x;
		logic m100, minm, prev, have;
		int w, seed;
		seed = $urandom(68951);
		prm[0] = 8'($urandom);
		prm[1] = 8'(10 + $urandom_range(190));
		prm[2] = 8'($urandom_range(100));
		prm[3] = 8'($urandom);
		prm[4] = 8'($urandom);
		x = prm[2];
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		// other page: diagnostic registers stay out of reach
		wr(ADDR_REFLECT_CONTROL, 16'h8000);
		check(16'(diag_active_o), 16'h0000);
		rc(ADDR_REFLECT_WINDOW, 16'h0000, 16'hFFFF);
		wr(ADDR_PAGE_SEL, 16'h0002);
		rc(ADDR_REFLECT_CONTROL, 16'h0000, 16'hFFFF);
		rc(ADDR_REFLECT_WINDOW, 16'h00FF, 16'hFFFF);
		for (int p = 0; p < 10; p++) begin
			wr(ADDR_QUALITY_DATA, 16'((p / 2) << 9) | 16'((p % 2) << 8));
			rc(ADDR_QUALITY_DATA, (p / 2 == 1) ? ((p % 2) ? 16'h00FF : 16'h0000)
				: ((p % 2) ? 16'h007F : 16'h0080), 16'h00FF);
		end
		for (int p = 0; p < 5; p++) begin
			wr(ADDR_QUALITY_DATA, 16'h2000 | 16'(p << 9));
			rc(ADDR_QUALITY_DATA, {8'h00, prm[p]}, 16'h00FF);
		end
		// thresholds set around the values just read
		wr(ADDR_QUALITY_DATA, 16'h4500 | {8'h00, x});
		wr(ADDR_QUALITY_DATA, 16'h4200 | {8'h00, prm[1]});
		wr(ADDR_QUALITY_DATA, 16'h0500);
		rc(ADDR_QUALITY_DATA, {8'h00, x}, 16'h00FF);
		wr(ADDR_QUALITY_DATA, 16'h0200);
		rc(ADDR_QUALITY_DATA, {8'h00, prm[1]}, 16'h00FF);
		prm[2] = x + 8'h01;
		repeat (4) @(negedge clk_i);
		rc(ADDR_QUALITY_CTRL, 16'h0000, 16'h03FF);
		prm[2] = x;
		wr(ADDR_QUALITY_CTRL, 16'h8000);
		repeat (4) @(negedge clk_i);
		rc(ADDR_QUALITY_CTRL, 16'h0000, 16'h03FF);
		wr(ADDR_INT_CTRL, 16'h0003);
		wr(ADDR_INT_STAT_MASK, 16'h0080);
		check(16'(int_n_o), 16'h0001);
		prm[2] = x + 8'h01;
		prm[1] = prm[1] - 8'h01;
		repeat (4) @(negedge clk_i);
		check(16'(int_n_o), 16'h0000);
		prm[2] = x;
		prm[1] = prm[1] + 8'h01;
		rc(ADDR_QUALITY_CTRL, 16'h0024, 16'h03FF);
		rc(ADDR_INT_STAT_MASK, 16'h8000, 16'h8000);
		repeat (3) @(negedge clk_i);
		check(16'(int_n_o), 16'h0001);
		////////////////////////////////////////////////////////////////////////////
		have = 1'b0;
		prev = 1'b0;
		for (int i = 0; i < 12; i++) begin
			m100 = (i < 8);
			w = m100 ? i : (i - 8) * 2 + 1;
			minm = i[0];
			d = 8'(20 + $urandom_range(80));
			a = 8'(40 + $urandom_range(80));
			if (minm)
				a = -a;
			st = d - 8'(1 + $urandom_range(15));
			sp = d + 8'(3 + $urandom_range(100));
			wr(ADDR_REFLECT_WINDOW, {st, sp});
			ctrl = {1'b1, m100, 1'($urandom), 1'($urandom), 1'b1, 3'(w), minm, 7'h0A};
			run(ctrl, d, a);
			check(16'({diag_active_o, onrx_o, monrx_o}), 16'({1'b1, ctrl[13:12]}));
			check(16'(n100), m100 ? 16'(exp_len(1'b1, 3'(w))) : 16'h0000);
			check(16'(n10), m100 ? 16'h0000 : 16'(exp_len(1'b0, 3'(w))));
			rc(ADDR_REFLECT_CONTROL, ctrl & 16'hF7FF, 16'hFFBF);
			if (m100 && w > 0) begin
				if (have)
					check(16'(neg_seen), {15'h0000, ~prev});
				prev = neg_seen;
				have = 1'b1;
			end
			if (w == 0) begin
				rc(ADDR_REFLECT_THRESH, 16'h0000, 16'h0001);
			end else begin
				rc(ADDR_REFLECT_PEAK, {d + 8'h01, a}, 16'hFFFF);
				rc(ADDR_REFLECT_THRESH, {d, 8'h01}, 16'hFF01);
			end
		end
		// send without enable: no pulse, last results stay
		run(16'h0D00, 8'h30, 8'h50);
		check(16'(n100 + n10), 16'h0000);
		rc(ADDR_REFLECT_PEAK, {d + 8'h01, a}, 16'hFFFF);
		// window opened after the echo: only noise qualifies
		wr(ADDR_REFLECT_WINDOW, {8'h40, 8'hFF});
		run(16'hCA0A, 8'h30, 8'h50);
		rc(ADDR_REFLECT_THRESH, 16'h0000, 16'h0001);
		stop_test();
	end
endmodule // testbench
